// file: core/occ_console.v
/*
 * Operator console status block: four register displays, fault flag
 * register read into the accumulator, bank control selector and display,
 * run lamp and computer status symbols.
 * Assumes all core event inputs are one-cycle pulses or levels synchronous
 * to clk_i, and master clear arrives as a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "occ_defines.vh"

module occ_console (
  // Clock and reset
  input  wire                                    clk_i,
  input  wire                                    reset_n_i,
  input  wire                                    master_clear_i,

  // Register values from the core, three per display
  input  wire [`OCC_NUM_DISP*3*`OCC_WORD_W-1:0]  disp_regs_i,

  // Operator display buttons
  input  wire [`OCC_NUM_DISP*3-1:0]              disp_sel_btn_i,
  input  wire [`OCC_NUM_DISP*`OCC_WORD_W-1:0]    disp_bit_btn_i,
  input  wire [`OCC_NUM_DISP-1:0]                disp_clr_btn_i,

  // Arithmetic observation
  input  wire                                    add_done_i,
  input  wire                                    sub_done_i,
  input  wire                                    arith_op_a_sign_i,
  input  wire                                    arith_op_b_sign_i,
  input  wire                                    arith_result_sign_i,
  input  wire                                    divide_fault_i,
  input  wire                                    proc_parity_err_i,
  input  wire [`OCC_FLT_CHAN_HI:`OCC_FLT_INT_PAR] chan_parity_err_i,

  // Instruction sequencer events
  input  wire                                    fault_flags_to_acc_instr_i,
  input  wire                                    clear_buffer_controls_instr_i,
  input  wire                                    start_i,
  input  wire                                    stop_instr_i,
  input  wire                                    halt_on_fault_instr_i,
  input  wire                                    halt_on_fault_g_instr_i,
  input  wire                                    cond_stop_halt_i,
  input  wire                                    operator_stop_i,
  input  wire                                    ext_function_instr_i,
  input  wire                                    selection_done_i,
  input  wire                                    normal_out_active_i,
  input  wire                                    normal_in_active_i,
  input  wire                                    in_waiting_i,
  input  wire                                    buffered_read_active_i,
  input  wire                                    buffered_write_active_i,
  input  wire                                    memory_parity_fault_i,
  input  wire                                    interrupt_seq_i,

  // Bank controls
  input  wire [`OCC_BSEL_W-1:0]                  last_ref_bank_ctl_i,
  input  wire                                    core_bank_sel_valid_i,
  input  wire [4*`OCC_BANK_W-1:0]                bank_values_i,
  input  wire [3:0]                              bank_choice_btn_i,
  input  wire [`OCC_BANK_W-1:0]                  bank_value_btn_i,
  input  wire                                    bank_clear_btn_i,
  input  wire                                    whole_bank_fill_button_i,

  // Display outputs
  output wire [`OCC_NUM_DISP*3-1:0]              disp_sel_lamp_o,
  output wire [`OCC_NUM_DISP*`OCC_WORD_W-1:0]    disp_shown_o,
  output wire [`OCC_NUM_DISP*`OCC_WORD_W-1:0]    reg_set_bits_o,
  output wire [`OCC_NUM_DISP-1:0]                reg_clear_o,

  // Accumulator load
  output reg  [`OCC_WORD_W-1:0]                  acc_load_value_o,
  output reg                                     acc_load_o,

  // Bank control outputs
  output reg  [3:0]                              bank_choice_lamp_o,
  output reg  [`OCC_BANK_W-1:0]                  bank_choice_display_o,
  output reg                                     bank_write_o,
  output reg  [`OCC_BSEL_W-1:0]                  bank_write_sel_o,
  output reg  [`OCC_BANK_W-1:0]                  bank_write_value_o,
  output reg                                     bank_clear_all_o,
  output reg                                     whole_bank_fill_lamp_o,

  // Status lamps
  output reg                                     run_lamp_o,
  output reg                                     fault_stop_sym_o,
  output reg                                     select_sym_o,
  output reg                                     out_sym_o,
  output reg                                     in_sym_o,
  output reg                                     buffered_read_active_o,
  output reg                                     buffered_write_active_o,
  output reg                                     channel_parity_fault_o,
  output reg                                     memory_parity_fault_o,
  output reg                                     service_seq_sym_o,
  output reg                                     arith_overflow_flag_o
);

  // Fault flag register fields
  reg                  ovf_q;
  reg                  proc_par_q;
  reg  [6:0]           chan_par_q;
  reg                  div_q;
  wire                 ovf_evt;
  wire [`OCC_WORD_W-1:0] ff_word;
  wire                 add_ovf;
  wire                 sub_ovf;

  // Bank selection state
  reg                  manual_q;
  reg  [`OCC_BSEL_W-1:0] bsel_q;
  wire [`OCC_BSEL_W-1:0] btn_sel;
  wire                 btn_any;
  wire [`OCC_BSEL_W-1:0] shown_sel;

  // Halt decode
  wire                 stop_evt;
  wire                 fault_halt;

  genvar g;

  ////////////////////////////////////////////////////////////////////////////
  // Register displays
  generate
    for (g = 0; g < `OCC_NUM_DISP; g = g + 1) begin : g_disp
      occ_display_unit u_disp (
        .clk_i      (clk_i),
        .reset_n_i  (reset_n_i),
        .running_i  (run_lamp_o),
        .regs_i     (disp_regs_i[g*3*`OCC_WORD_W +: 3*`OCC_WORD_W]),
        .sel_btn_i  (disp_sel_btn_i[g*3 +: 3]),
        .bit_btn_i  (disp_bit_btn_i[g*`OCC_WORD_W +: `OCC_WORD_W]),
        .clr_btn_i  (disp_clr_btn_i[g]),
        .sel_lamp_o (disp_sel_lamp_o[g*3 +: 3]),
        .shown_o    (disp_shown_o[g*`OCC_WORD_W +: `OCC_WORD_W]),
        .set_bits_o (reg_set_bits_o[g*`OCC_WORD_W +: `OCC_WORD_W]),
        .clr_o      (reg_clear_o[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags

  // illegal sign change
  // Add: like signs in, other sign out
  assign add_ovf = add_done_i &&
                   (arith_op_a_sign_i == arith_op_b_sign_i) &&
                   (arith_result_sign_i != arith_op_a_sign_i);
  // Subtract flips the second operand sign, so like signs are tested after it
  assign sub_ovf = sub_done_i &&
                   (arith_op_a_sign_i != arith_op_b_sign_i) &&
                   (arith_result_sign_i != arith_op_a_sign_i);
  assign ovf_evt = add_ovf | sub_ovf;

  assign ff_word = {ovf_q, ovf_q, proc_par_q, 2'h3, chan_par_q, div_q};

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ovf_q            <= 1'b0;
      proc_par_q       <= 1'b0;
      chan_par_q       <= 7'h00;
      div_q            <= 1'b0;
      acc_load_o       <= 1'b0;
      acc_load_value_o <= 13'h0000;
    end else if (master_clear_i) begin
      ovf_q            <= 1'b0;
      proc_par_q       <= 1'b0;
      chan_par_q       <= 7'h00;
      div_q            <= 1'b0;
      acc_load_o       <= 1'b0;
      acc_load_value_o <= 13'h0000;
    end else begin
      acc_load_o       <= fault_flags_to_acc_instr_i;
      acc_load_value_o <= ff_word;

      ovf_q      <= ovf_evt | (ovf_q & ~fault_flags_to_acc_instr_i);
      proc_par_q <= proc_parity_err_i | (proc_par_q & ~fault_flags_to_acc_instr_i);
      div_q      <= divide_fault_i | (div_q & ~fault_flags_to_acc_instr_i);

      // channel flags cleared by buffer clear
      chan_par_q <= chan_parity_err_i | (chan_par_q & {7{~clear_buffer_controls_instr_i}});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bank control selector
  function [`OCC_BSEL_W-1:0] enc4;
    input [3:0] v;
    begin
      if (v[0])
        enc4 = `OCC_BSEL_BFR;
      else if (v[1])
        enc4 = `OCC_BSEL_DIR;
      else if (v[2])
        enc4 = `OCC_BSEL_IND;
      else
        enc4 = `OCC_BSEL_REL;
    end
  endfunction

  assign btn_sel   = enc4(bank_choice_btn_i);
  assign btn_any   = |bank_choice_btn_i;

  // last referenced bank unless manual
  // Next choice, so lamp and display follow a press or master clear at once
  assign shown_sel = master_clear_i ? `OCC_BSEL_REL :
                     btn_any        ? btn_sel :
                     (manual_q && !start_i) ? bsel_q : last_ref_bank_ctl_i;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      manual_q               <= 1'b0;
      bsel_q                 <= `OCC_BSEL_REL;
      bank_choice_lamp_o     <= 4'h8;
      bank_choice_display_o  <= `OCC_BANK_RESET;
      bank_write_o           <= 1'b0;
      bank_write_sel_o       <= `OCC_BSEL_REL;
      bank_write_value_o     <= `OCC_BANK_RESET;
      bank_clear_all_o       <= 1'b0;
      whole_bank_fill_lamp_o <= 1'b0;
    end else begin
      whole_bank_fill_lamp_o <= whole_bank_fill_button_i;
      bank_clear_all_o <= master_clear_i & bank_clear_btn_i;

      if (master_clear_i) begin
        manual_q <= 1'b1;
        bsel_q   <= `OCC_BSEL_REL;
      end else if (btn_any) begin
        manual_q <= 1'b1;
        bsel_q   <= btn_sel;
      end else if (start_i) begin
        manual_q <= 1'b0;
      end

      bank_write_o       <= ~master_clear_i & (bank_clear_btn_i | (|bank_value_btn_i));
      bank_write_sel_o   <= shown_sel;
      bank_write_value_o <= bank_clear_btn_i ? `OCC_BANK_RESET : bank_value_btn_i;
      bank_choice_display_o <= bank_values_i[shown_sel*`OCC_BANK_W +: `OCC_BANK_W];

      // lamp also lit by core selection
      bank_choice_lamp_o <= (4'h1 << shown_sel) |
                            (core_bank_sel_valid_i ? (4'h1 << last_ref_bank_ctl_i) : 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run lamp and status symbols
  // halt sources, stop beats start
  assign stop_evt   = stop_instr_i | halt_on_fault_instr_i | halt_on_fault_g_instr_i |
                      cond_stop_halt_i | operator_stop_i;
  assign fault_halt = halt_on_fault_instr_i | halt_on_fault_g_instr_i;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_lamp_o              <= 1'b0;
      fault_stop_sym_o        <= 1'b0;
      select_sym_o            <= 1'b0;
      out_sym_o               <= 1'b0;
      in_sym_o                <= 1'b0;
      buffered_read_active_o  <= 1'b0;
      buffered_write_active_o <= 1'b0;
      channel_parity_fault_o  <= 1'b0;
      memory_parity_fault_o   <= 1'b0;
      service_seq_sym_o       <= 1'b0;
      arith_overflow_flag_o   <= 1'b0;
    end else if (master_clear_i) begin
      run_lamp_o              <= 1'b0;
      fault_stop_sym_o        <= 1'b0;
      select_sym_o            <= 1'b0;
      out_sym_o               <= 1'b0;
      in_sym_o                <= 1'b0;
      buffered_read_active_o  <= 1'b0;
      buffered_write_active_o <= 1'b0;
      channel_parity_fault_o  <= 1'b0;
      memory_parity_fault_o   <= 1'b0;
      service_seq_sym_o       <= 1'b0;
      arith_overflow_flag_o   <= 1'b0;
    end else begin
      // run lamp, stop wins over start
      if (stop_evt)
        run_lamp_o <= 1'b0;
      else if (start_i)
        run_lamp_o <= 1'b1;

      if (fault_halt)
        fault_stop_sym_o <= 1'b1;
      else if (start_i)
        fault_stop_sym_o <= 1'b0;

      if (ext_function_instr_i)
        select_sym_o <= 1'b1;
      else if (selection_done_i)
        select_sym_o <= 1'b0;

      out_sym_o <= normal_out_active_i;
      in_sym_o  <= normal_in_active_i | in_waiting_i;

      buffered_read_active_o  <= buffered_read_active_i;
      buffered_write_active_o <= buffered_write_active_i;

      channel_parity_fault_o <= channel_parity_fault_o | (|chan_parity_err_i);
      memory_parity_fault_o  <= memory_parity_fault_o | memory_parity_fault_i;

      service_seq_sym_o     <= interrupt_seq_i;
      arith_overflow_flag_o <= arith_overflow_flag_o | ovf_evt;
    end
  end

endmodule // occ_console

// file: core/occ_defines.vh
/*
 * Constants for the operator console status block: register selector codes,
 * fault flag bit positions, bank control codes and reset values.
 * Assumes inclusion by bare name from the core/ design files.
 */
`ifndef OCC_DEFINES_VH
`define OCC_DEFINES_VH

// Register word and display geometry
`define OCC_WORD_W        13
`define OCC_NUM_DISP      4
`define OCC_SEL_W         2
`define OCC_SEL_NONE      2'h3

// Fault flag register layout, accumulator bit positions
`define OCC_FF_W          10
`define OCC_FLT_OVF_HI    12
`define OCC_FLT_OVF_LO    11
`define OCC_FLT_PROC_PAR  10
`define OCC_FLT_ONES_HI   9
`define OCC_FLT_ONES_LO   8
`define OCC_FLT_CHAN_HI   7
`define OCC_FLT_CHAN_LO   2
`define OCC_FLT_INT_PAR   1
`define OCC_FLT_DIV       0
`define OCC_FF_RESET      10'h000

// Bank controls
`define OCC_BANK_W        5
`define OCC_BSEL_W        2
`define OCC_BSEL_BFR      2'h0
`define OCC_BSEL_DIR      2'h1
`define OCC_BSEL_IND      2'h2
`define OCC_BSEL_REL      2'h3
`define OCC_BANK_RESET    5'h00

// Register selector reset: first register of each display
`define OCC_RSEL_RESET    2'h0

`endif

// file: core/occ_display_unit.v
/*
 * One register display: radio-group selector, halted-only shown word,
 * and manual set/clear strobes toward the single editable register.
 * Assumes buttons are one-cycle synchronous pulses from a debouncer.
 */
`timescale 1ns/1ps
`include "occ_defines.vh"

module occ_display_unit (
  // Clock and reset
  input  wire                        clk_i,
  input  wire                        reset_n_i,
  // Processor state
  input  wire                        running_i,
  input  wire [3*`OCC_WORD_W-1:0]    regs_i,
  // Operator buttons
  input  wire [2:0]                  sel_btn_i,
  input  wire [`OCC_WORD_W-1:0]      bit_btn_i,
  input  wire                        clr_btn_i,
  // Lamps and edit strobes
  output reg  [2:0]                  sel_lamp_o,
  output reg  [`OCC_WORD_W-1:0]      shown_o,
  output reg  [`OCC_WORD_W-1:0]      set_bits_o,
  output reg                         clr_o
);

  // Selector index 0 is the editable register of this display
  reg  [`OCC_SEL_W-1:0] sel_q;
  reg  [`OCC_SEL_W-1:0] sel_d;
  wire                  edit_ok;

  ////////////////////////////////////////////////////////////////////////////
  // radio group select
  // Lowest button wins when several are pressed together
  always @* begin
    sel_d = sel_q;
    if (sel_btn_i[0])
      sel_d = 2'h0;
    else if (sel_btn_i[1])
      sel_d = 2'h1;
    else if (sel_btn_i[2])
      sel_d = 2'h2;
  end

  assign edit_ok = (sel_q == 2'h0) && !running_i;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q      <= `OCC_RSEL_RESET;
      sel_lamp_o <= 3'h1;
      shown_o    <= 13'h0000;
      set_bits_o <= 13'h0000;
      clr_o      <= 1'b0;
    end else begin
      sel_q      <= sel_d;
      sel_lamp_o <= 3'h1 << sel_d;
      if (running_i)
        shown_o <= 13'h0000;
      else
        shown_o <= regs_i[sel_q*`OCC_WORD_W +: `OCC_WORD_W];
      set_bits_o <= edit_ok ? bit_btn_i : 13'h0000;
      clr_o      <= edit_ok & clr_btn_i;
    end
  end

endmodule // occ_display_unit

// file: test/occ_console_checker.sv
/* Assertion checker for the operator console status block.
   Assumes it is bound into occ_console and sees only its ports. */
`timescale 1ns/1ps
`include "occ_defines.vh"
module occ_console_checker (
  // Clock, reset, events and display select lamps
  input wire logic                        clk_i, reset_n_i, master_clear_i, fault_flags_to_acc_instr_i,
  input wire logic                        clear_buffer_controls_instr_i, divide_fault_i, proc_parity_err_i,
  input wire logic                        add_done_i, arith_op_a_sign_i, arith_op_b_sign_i, arith_result_sign_i,
  input wire logic                        stop_instr_i, halt_on_fault_instr_i, ext_function_instr_i, bank_clear_btn_i,
  input wire logic [`OCC_NUM_DISP*3-1:0]  disp_sel_btn_i, disp_sel_lamp_o,
  // Outputs watched
  input wire logic                        acc_load_o, run_lamp_o, fault_stop_sym_o, select_sym_o,
  input wire logic                        bank_clear_all_o, arith_overflow_flag_o,
  input wire logic [`OCC_WORD_W-1:0]      acc_load_value_o,
  input wire logic [3:0]                  bank_choice_lamp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////
  flag_read_a: assert property (fault_flags_to_acc_instr_i |=> acc_load_o)
    else $error("no accumulator load after flag read");
  spare_ones_a: assert property (acc_load_o |-> acc_load_value_o[9:8] == 2'b11)
    else $error("spare flag bits not one");
  div_flag_a: assert property (divide_fault_i && !master_clear_i ##1 !fault_flags_to_acc_instr_i
    && !master_clear_i ##1 fault_flags_to_acc_instr_i && !master_clear_i |=> acc_load_value_o[0])
    else $error("divide flag missing");
  read_clears_a: assert property (fault_flags_to_acc_instr_i && !divide_fault_i && !proc_parity_err_i && !master_clear_i
    ##1 fault_flags_to_acc_instr_i |=> !acc_load_value_o[0] && !acc_load_value_o[10]) else $error("flags not cleared by read");
  chan_keep_a: assert property (fault_flags_to_acc_instr_i && !clear_buffer_controls_instr_i && !master_clear_i
    ##1 fault_flags_to_acc_instr_i && !clear_buffer_controls_instr_i && !master_clear_i && acc_load_value_o[2]
    |=> acc_load_value_o[2]) else $error("channel flag lost on read");
  stop_dark_a: assert property (stop_instr_i |=> !run_lamp_o) else $error("run lamp lit after stop");
  fault_sym_a: assert property (halt_on_fault_instr_i && !master_clear_i |=> fault_stop_sym_o)
    else $error("fault stop symbol missing");
  sel_sym_a: assert property (ext_function_instr_i && !master_clear_i |=> select_sym_o)
    else $error("selection symbol missing");
  radio_sel_a: assert property (disp_sel_btn_i[2:0] == 3'b010 |=> disp_sel_lamp_o[2:0] == 3'b010)
    else $error("select lamps not one-hot");
  bank_wipe_a: assert property (master_clear_i && bank_clear_btn_i |=> bank_clear_all_o)
    else $error("bank clear all missing");
  rel_pick_a: assert property (master_clear_i |=> bank_choice_lamp_o[3]) else $error("program bank not chosen");
  ovf_seen_a: assert property (add_done_i && !master_clear_i && arith_op_a_sign_i == arith_op_b_sign_i
    && arith_result_sign_i != arith_op_a_sign_i |=> arith_overflow_flag_o) else $error("overflow not seen");
endmodule // occ_console_checker

bind occ_console occ_console_checker chk_u (.clk_i, .reset_n_i, .master_clear_i, .fault_flags_to_acc_instr_i,
  .clear_buffer_controls_instr_i, .divide_fault_i, .proc_parity_err_i, .add_done_i, .arith_op_a_sign_i,
  .arith_op_b_sign_i, .arith_result_sign_i, .stop_instr_i, .halt_on_fault_instr_i, .ext_function_instr_i,
  .bank_clear_btn_i, .disp_sel_btn_i, .disp_sel_lamp_o, .acc_load_o, .run_lamp_o, .fault_stop_sym_o,
  .select_sym_o, .bank_clear_all_o, .arith_overflow_flag_o, .acc_load_value_o, .bank_choice_lamp_o);

// file: test/occ_operator.sv
/* Console operator model: presses one momentary pushbutton at a time.
   Assumes the bench changes press_i and idx_i at the falling clock edge. */
`timescale 1ns/1ps
module occ_operator (
  // Request from the bench
  input  wire logic        press_i,
  input  wire logic [6:0]  idx_i,
  // Pushbuttons toward the console
  output wire logic [11:0] sel_btn_o,
  output wire logic [51:0] bit_btn_o,
  output wire logic [3:0]  clr_btn_o,
  output wire logic [3:0]  choice_btn_o,
  output wire logic [4:0]  value_btn_o
);
  // One hand, one button: a radio group never sees two presses at once
  assign {value_btn_o, choice_btn_o, clr_btn_o, bit_btn_o, sel_btn_o} = press_i ? (77'h1 << idx_i) : 77'h0;
endmodule // occ_operator

// file: test/test_operator_console_status.sv
/* Self-checking bench for occ_console with an operator model.
   Assumes inputs change at the falling edge and reset is held 16 cycles. */
`timescale 1ns/1ps
module test_operator_console_status;
  localparam MC = 0, RD = 5, CBC = 6, START = 7, STOP = 8, EXT = 13, SDONE = 14, MEMP = 15;
  logic clk_i = 0, reset_n_i = 0, press = 0, bank_clear_btn_i = 0, core_sel = 0;
  logic [6:0] idx = 0;
  logic [22:0] ev = 0;
  logic [5:0] lv = 0;
  logic [2:0] sg = 0;
  logic [1:0] last_ref_bank_ctl_i = 2;
  logic [155:0] disp_regs_i = 0;
  logic [19:0] bank_values_i = 0;
  logic [15:0] r = 16'h0020;
  integer num_errors = 0, num_checks = 0, cyc = 0, i, d, k;
  wire master_clear_i, add_done_i, sub_done_i, divide_fault_i, proc_parity_err_i, fault_flags_to_acc_instr_i;
  wire clear_buffer_controls_instr_i, start_i, stop_instr_i, halt_on_fault_instr_i, halt_on_fault_g_instr_i;
  wire cond_stop_halt_i, operator_stop_i, ext_function_instr_i, selection_done_i, memory_parity_fault_i;
  wire normal_out_active_i, normal_in_active_i, in_waiting_i, buffered_read_active_i, buffered_write_active_i;
  wire interrupt_seq_i, arith_op_a_sign_i, arith_op_b_sign_i, arith_result_sign_i;
  wire [7:1] chan_parity_err_i;
  wire [11:0] disp_sel_btn_i, disp_sel_lamp_o;
  wire [51:0] disp_bit_btn_i, disp_shown_o, reg_set_bits_o;
  wire [3:0] disp_clr_btn_i, bank_choice_btn_i, reg_clear_o, bank_choice_lamp_o;
  wire [4:0] bank_value_btn_i, bank_choice_display_o, bank_write_value_o;
  wire [12:0] acc_load_value_o;
  wire [1:0] bank_write_sel_o;
  wire acc_load_o, bank_write_o, bank_clear_all_o, whole_bank_fill_lamp_o, run_lamp_o, fault_stop_sym_o;
  wire select_sym_o, out_sym_o, in_sym_o, buffered_read_active_o, buffered_write_active_o;
  wire channel_parity_fault_o, memory_parity_fault_o, service_seq_sym_o, arith_overflow_flag_o;
  assign {chan_parity_err_i, memory_parity_fault_i, selection_done_i, ext_function_instr_i, operator_stop_i,
          cond_stop_halt_i, halt_on_fault_g_instr_i, halt_on_fault_instr_i, stop_instr_i, start_i,
          clear_buffer_controls_instr_i, fault_flags_to_acc_instr_i, proc_parity_err_i, divide_fault_i,
          sub_done_i, add_done_i, master_clear_i} = ev;
  assign {interrupt_seq_i, buffered_write_active_i, buffered_read_active_i, in_waiting_i, normal_in_active_i,
          normal_out_active_i} = lv;
  assign {arith_result_sign_i, arith_op_b_sign_i, arith_op_a_sign_i} = sg;
  ////////////////////////////////////////////////////////////////////////
  occ_console uut (.clk_i, .reset_n_i, .master_clear_i, .disp_regs_i, .disp_sel_btn_i, .disp_bit_btn_i,
    .disp_clr_btn_i, .add_done_i, .sub_done_i, .arith_op_a_sign_i, .arith_op_b_sign_i, .arith_result_sign_i,
    .divide_fault_i, .proc_parity_err_i, .chan_parity_err_i, .fault_flags_to_acc_instr_i,
    .clear_buffer_controls_instr_i, .start_i, .stop_instr_i, .halt_on_fault_instr_i, .halt_on_fault_g_instr_i,
    .cond_stop_halt_i, .operator_stop_i, .ext_function_instr_i, .selection_done_i, .normal_out_active_i,
    .normal_in_active_i, .in_waiting_i, .buffered_read_active_i, .buffered_write_active_i,
    .memory_parity_fault_i, .interrupt_seq_i, .last_ref_bank_ctl_i, .core_bank_sel_valid_i(core_sel),
    .bank_values_i, .bank_choice_btn_i, .bank_value_btn_i, .bank_clear_btn_i,
    .whole_bank_fill_button_i(bank_clear_btn_i),
    .disp_sel_lamp_o, .disp_shown_o, .reg_set_bits_o, .reg_clear_o, .acc_load_value_o, .acc_load_o,
    .bank_choice_lamp_o, .bank_choice_display_o, .bank_write_o, .bank_write_sel_o, .bank_write_value_o,
    .bank_clear_all_o, .whole_bank_fill_lamp_o, .run_lamp_o, .fault_stop_sym_o, .select_sym_o, .out_sym_o,
    .in_sym_o, .buffered_read_active_o, .buffered_write_active_o, .channel_parity_fault_o,
    .memory_parity_fault_o, .service_seq_sym_o, .arith_overflow_flag_o);
  occ_operator op (.press_i(press), .idx_i(idx), .sel_btn_o(disp_sel_btn_i), .bit_btn_o(disp_bit_btn_i),
    .clr_btn_o(disp_clr_btn_i), .choice_btn_o(bank_choice_btn_i), .value_btn_o(bank_value_btn_i));
  ////////////////////////////////////////////////////////////////////////
  always #5 clk_i = ~clk_i;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Overflow only when the result sign departs from operand A
  function [12:0] flags(input [15:0] v);
    flags = {{2{v[0] & (v[4] != v[3])}}, v[6], 2'b11, v[13:7], v[5]};
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task fire(input [22:0] m, input integer n);
    @(negedge clk_i);
    ev = m;
    repeat (n) @(negedge clk_i);
    ev = 0;
  endtask
  task push(input integer b);
    @(negedge clk_i);
    press = 1;
    idx = b[6:0];
    @(negedge clk_i);
    press = 0;
  endtask
  task end_sim;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Cut a hang short well beyond the few hundred cycles the run needs
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  initial begin
    repeat (16) @(negedge clk_i);
    chk({disp_sel_lamp_o, bank_choice_lamp_o, run_lamp_o, acc_load_o}, {12'h249, 4'h8, 2'b00});
    reset_n_i = 1;
    @(negedge clk_i);
    for (i = 0; i < 6; i++) begin
      r = lfsr(r);
      sg = {r[4], r[3] ^ r[1], r[3]};
      fire({r[13:7], 11'h0, r[6], r[5], r[1] & r[0], ~r[1] & r[0], 1'b0}, 1);
      fire(1 << RD, 1);
      chk({acc_load_o, acc_load_value_o}, {1'b1, flags(r)});
      fire(1 << RD, 2);
      chk(acc_load_value_o, {5'h03, r[13:7], 1'b0});
      fire(1 << (i[0] ? MC : CBC), 1);
      fire(1 << RD, 1);
      chk(acc_load_value_o, 13'h0300);
    end
    for (i = 0; i < 12; i++) begin
      r = lfsr(r);
      disp_regs_i[i*13+:13] = r[12:0];
    end
    for (d = 0; d < 4; d++) begin
      k = r[d+:2] % 3;
      push(d * 3 + k);
      @(negedge clk_i);
      chk({disp_sel_lamp_o[d*3+:3], disp_shown_o[d*13+:13]}, {3'b1 << k, disp_regs_i[(d*3+k)*13+:13]});
      k = r[d*3+:4] % 13;
      push(d * 3);
      push(12 + d * 13 + k);
      chk(reg_set_bits_o, 64'h1 << (d * 13 + k));
      push(64 + d);
      chk(reg_clear_o, 64'h1 << d);
      push(d * 3 + 1);
      push(12 + d * 13 + k);
      chk(reg_set_bits_o, 0);
    end
    for (i = STOP; i <= 12; i++) begin
      fire(1 << START, 1);
      chk({run_lamp_o, fault_stop_sym_o}, 2'b10);
      @(negedge clk_i);
      chk(disp_shown_o, 0);
      fire(1 << i, 1);
      chk({run_lamp_o, fault_stop_sym_o}, {1'b0, i == 9 || i == 10});
    end
    fire((1 << START) | (1 << STOP), 1);
    chk(run_lamp_o, 0);
    r = lfsr(r);
    bank_values_i = {r[3:0], r};
    bank_clear_btn_i = 1;
    fire(1 << MC, 1);
    chk({bank_clear_all_o, whole_bank_fill_lamp_o, bank_choice_lamp_o}, 6'h38);
    bank_clear_btn_i = 0;
    @(negedge clk_i);
    chk(bank_choice_display_o, bank_values_i[15+:5]);
    core_sel = 1;
    push(69);
    @(negedge clk_i);
    chk({bank_choice_lamp_o, bank_choice_display_o}, {4'h6, bank_values_i[5+:5]});
    push(74);
    chk({bank_write_o, bank_write_sel_o, bank_write_value_o}, {3'b101, 5'h04});
    fire(1 << START, 1);
    @(negedge clk_i);
    chk(bank_choice_display_o, bank_values_i[10+:5]);
    fire(1 << STOP, 1);
    fire(1 << EXT, 1);
    repeat (3) @(negedge clk_i);
    chk(select_sym_o, 1);
    fire(1 << SDONE, 1);
    chk(select_sym_o, 0);
    fire((1 << MEMP) | (1 << 18), 1);
    chk({memory_parity_fault_o, channel_parity_fault_o}, 2'b11);
    for (i = 0; i < 5; i++) begin
      r = lfsr(r);
      @(negedge clk_i);
      lv = r[5:0];
      repeat (2) @(negedge clk_i);
      chk({service_seq_sym_o, buffered_write_active_o, buffered_read_active_o, in_sym_o, out_sym_o},
          {lv[5:3], lv[2] | lv[1], lv[0]});
    end
    end_sim;
  end
endmodule // test_operator_console_status
